/* common/bsv_defines.svh */
`ifndef BSV_DEFINES_SVH
`define BSV_DEFINES_SVH

// ************************************************************
// bus target address and register map
// ************************************************************
`define BSV_TARGET_ADDR   7'h6C
`define BSV_REG_CTL       8'h02
`define BSV_REG_SLP       8'h03
`define BSV_CTL_RESET     8'hCF
`define BSV_SLP_RESET     8'h0F

// ************************************************************
// field positions
// ************************************************************
`define BSV_CODE_MSB      5
`define BSV_EN_BIT        6
`define BSV_OSC_BIT       7
`define BSV_SLEW_BIT      6
`define BSV_RDLY_BIT      7

// ************************************************************
// voltage code mapping, millivolts
// ************************************************************
`define BSV_VMIN_MV       625
`define BSV_VSTEP_MV      25

// ************************************************************
// slew rates, microvolts per microsecond
// ************************************************************
`define BSV_SLEW_SLOW_UV  190
`define BSV_SLEW_FAST_UV  380

// ************************************************************
// timing
// ************************************************************
`define BSV_CLK_NS        10
`define BSV_RDLY_SHORT_NS 1070000
`define BSV_RDLY_LONG_NS  8400000
`define BSV_BYTE_BITS     4'h8

`endif

/* common/bsv_pkg.sv */
`default_nettype none
package bsv_pkg;

  // bus target sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_PTR,
    ST_PACK,
    ST_WR,
    ST_WACK,
    ST_RD,
    ST_RACK
  } bsv_state_t;

endpackage
`default_nettype wire

/* design/bsv_code_to_mv.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bsv_defines.svh"

module bsv_code_to_mv (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // code in, target out
  input  wire logic [5:0]  code,
  output var  logic [11:0] mv_ff
);
  import bsv_pkg::*;

  logic [11:0] nxt_mv;

  // linear map, widths sized so the top code never wraps
  assign nxt_mv = 12'(`BSV_VMIN_MV) + 12'(code) * 12'(`BSV_VSTEP_MV);

  // registered so downstream sees a clean value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mv_ff <= 12'h000;
    end else begin
      mv_ff <= nxt_mv;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_mv_linear;
    @(posedge clk) disable iff (!rstn)
    $past(rstn) |-> mv_ff == 12'(`BSV_VMIN_MV + `BSV_VSTEP_MV * int'($past(code)));
  endproperty
  a_mv_linear: assert property (p_mv_linear) else $error("voltage map wrong");

endmodule
`default_nettype wire

/* design/bsv_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bsv_defines.svh"

module bsv_regs #(
  parameter int unsigned RDLY_SHORT_CYC = `BSV_RDLY_SHORT_NS / `BSV_CLK_NS,
  parameter int unsigned RDLY_LONG_CYC  = `BSV_RDLY_LONG_NS / `BSV_CLK_NS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // two-wire bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // main converter controls
  output logic             osc_enable,
  output logic             converter_enable_bit,
  output logic [5:0]       converter_voltage_code,
  output logic [11:0]      main_target_mv,
  // sleep controls
  output logic [5:0]       light_load_voltage_code,
  output logic             output_slew_rate_select,
  output logic             reset_delay_select,
  output logic [11:0]      sleep_target_mv,
  output logic [8:0]       slew_uv_per_us,
  output logic [19:0]      reset_delay_cycles
);
  import bsv_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  bsv_state_t  state_ff;
  bsv_state_t  nxt_state;
  logic [3:0]  bit_cnt_ff;
  logic [3:0]  nxt_bit_cnt;
  logic [7:0]  shift_ff;
  logic [7:0]  nxt_shift;
  logic [7:0]  ptr_ff;
  logic [7:0]  nxt_ptr;
  logic        rw_ff;
  logic        nxt_rw;
  logic        nack_ff;
  logic        nxt_nack;
  logic        scl_q_ff;
  logic        sda_q_ff;
  logic [7:0]  ctl_ff;
  logic [7:0]  nxt_ctl;
  logic [7:0]  slp_ff;
  logic [7:0]  nxt_slp;
  logic [8:0]  slew_ff;
  logic [19:0] rdly_ff;
  logic        wr_stb;

  // ************************************************************
  // bus event decode
  // ************************************************************
  wire       scl_rise = scl_in & ~scl_q_ff;
  wire       scl_fall = ~scl_in & scl_q_ff;
  wire       start_ev = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
  wire       stop_ev  = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
  wire       byte_end = scl_fall && (bit_cnt_ff == `BSV_BYTE_BITS);
  wire       addr_hit = (shift_ff[7:1] == `BSV_TARGET_ADDR);
  wire       hit_ctl  = (ptr_ff == `BSV_REG_CTL);
  wire       hit_slp  = (ptr_ff == `BSV_REG_SLP);
  // unmapped offsets read as zero and drop writes
  wire [7:0] rd_byte  = hit_ctl ? ctl_ff : (hit_slp ? slp_ff : 8'h00);
  wire       in_ack   = (state_ff == ST_AACK) || (state_ff == ST_PACK) ||
                        (state_ff == ST_WACK);

  // open drain: only ever pull low, release otherwise
  assign sda_out = 1'b0;
  assign sda_oe  = in_ack || ((state_ff == ST_RD) && !shift_ff[7]);

  // ************************************************************
  // target sequencer
  // ************************************************************
  // a start anywhere restarts, so a repeated start turns write into read
  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift   = shift_ff;
    nxt_ptr     = ptr_ff;
    nxt_rw      = rw_ff;
    nxt_nack    = nack_ff;
    wr_stb      = 1'b0;
    if (start_ev) begin
      nxt_state   = ST_ADDR;
      nxt_bit_cnt = 4'h0;
    end else if (stop_ev) begin
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_ADDR, ST_PTR, ST_WR: begin
          if (scl_rise && (bit_cnt_ff != `BSV_BYTE_BITS)) begin
            nxt_shift   = {shift_ff[6:0], sda_in};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (byte_end) begin
            nxt_bit_cnt = 4'h0;
            if (state_ff == ST_ADDR) begin
              // foreign address: stay silent until the next start
              nxt_state = addr_hit ? ST_AACK : ST_IDLE;
              nxt_rw    = shift_ff[0];
            end else if (state_ff == ST_PTR) begin
              nxt_ptr   = shift_ff;
              nxt_state = ST_PACK;
            end else begin
              wr_stb    = 1'b1;
              nxt_ptr   = ptr_ff + 8'h01;
              nxt_state = ST_WACK;
            end
          end
        end
        ST_AACK, ST_PACK, ST_WACK: begin
          if (scl_fall) begin
            if ((state_ff == ST_AACK) && rw_ff) begin
              nxt_shift = rd_byte;
              nxt_state = ST_RD;
            end else if (state_ff == ST_AACK) begin
              nxt_state = ST_PTR;
            end else begin
              nxt_state = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall && (bit_cnt_ff == 4'h7)) begin
            nxt_bit_cnt = 4'h0;
            nxt_ptr     = ptr_ff + 8'h01;
            nxt_state   = ST_RACK;
          end else if (scl_fall) begin
            nxt_shift   = {shift_ff[6:0], 1'b0};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nxt_nack = sda_in;
          end else if (scl_fall) begin
            nxt_shift = rd_byte;
            nxt_state = nack_ff ? ST_IDLE : ST_RD;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  assign nxt_ctl = (wr_stb && hit_ctl) ? shift_ff : ctl_ff;
  assign nxt_slp = (wr_stb && hit_slp) ? shift_ff : slp_ff;

  // sequencer flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      ptr_ff     <= 8'h00;
      rw_ff      <= 1'b0;
      nack_ff    <= 1'b1;
      scl_q_ff   <= 1'b1;
      sda_q_ff   <= 1'b1;
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff   <= nxt_shift;
      ptr_ff     <= nxt_ptr;
      rw_ff      <= nxt_rw;
      nack_ff    <= nxt_nack;
      scl_q_ff   <= scl_in;
      sda_q_ff   <= sda_in;
    end
  end

  // control registers come up at their defaults
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_ff <= `BSV_CTL_RESET;
      slp_ff <= `BSV_SLP_RESET;
    end else begin
      ctl_ff <= nxt_ctl;
      slp_ff <= nxt_slp;
    end
  end

  // decoded slew and delay, registered for the analog side
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slew_ff <= 9'(`BSV_SLEW_SLOW_UV);
      rdly_ff <= 20'(RDLY_SHORT_CYC);
    end else begin
      slew_ff <= slp_ff[`BSV_SLEW_BIT] ? 9'(`BSV_SLEW_FAST_UV) : 9'(`BSV_SLEW_SLOW_UV);
      rdly_ff <= slp_ff[`BSV_RDLY_BIT] ? 20'(RDLY_LONG_CYC) : 20'(RDLY_SHORT_CYC);
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // the mode switch caution is left to the host, nothing is interlocked
  assign osc_enable              = ctl_ff[`BSV_OSC_BIT];
  assign converter_enable_bit    = ctl_ff[`BSV_EN_BIT];
  assign converter_voltage_code  = ctl_ff[`BSV_CODE_MSB:0];
  assign light_load_voltage_code = slp_ff[`BSV_CODE_MSB:0];
  assign output_slew_rate_select = slp_ff[`BSV_SLEW_BIT];
  assign reset_delay_select      = slp_ff[`BSV_RDLY_BIT];
  assign slew_uv_per_us          = slew_ff;
  assign reset_delay_cycles      = rdly_ff;

  // same linear map for both codes
  bsv_code_to_mv u_main_mv (
    .clk   (clk),
    .rstn  (rstn),
    .code  (converter_voltage_code),
    .mv_ff (main_target_mv)
  );

  bsv_code_to_mv u_sleep_mv (
    .clk   (clk),
    .rstn  (rstn),
    .code  (light_load_voltage_code),
    .mv_ff (sleep_target_mv)
  );

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_addr_match;
    (state_ff == ST_ADDR) && byte_end && addr_hit && !start_ev && !stop_ev;
  endsequence
  sequence s_addr_miss;
    (state_ff == ST_ADDR) && byte_end && !addr_hit && !start_ev && !stop_ev;
  endsequence
  sequence s_slp_write;
    (state_ff == ST_WR) && byte_end && hit_slp && !start_ev && !stop_ev;
  endsequence
  sequence s_ctl_write;
    (state_ff == ST_WR) && byte_end && hit_ctl && !start_ev && !stop_ev;
  endsequence

  property p_addr_ack;
    @(posedge clk) disable iff (!rstn)
    s_addr_match |=> sda_oe && (rw_ff == $past(shift_ff[0]));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
  property p_addr_ignore;
    @(posedge clk) disable iff (!rstn)
    s_addr_miss |=> !sda_oe && (state_ff == ST_IDLE);
  endproperty
  a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address answered");
  property p_read_drive;
    @(posedge clk) disable iff (!rstn)
    (state_ff == ST_AACK) && rw_ff && scl_fall && !start_ev && !stop_ev
      |=> (state_ff == ST_RD) && (sda_oe == !$past(rd_byte[7]));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");
  property p_reset_defaults;
    @(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> (ctl_ff == 8'hCF) && (slp_ff == 8'h0F) && converter_enable_bit;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad defaults");
  property p_sleep_write;
    @(posedge clk) disable iff (!rstn)
    s_slp_write |=> ##1 light_load_voltage_code == $past(shift_ff[5:0], 2);
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("sleep code not stored");
  property p_enable_write;
    @(posedge clk) disable iff (!rstn)
    s_ctl_write |=> converter_enable_bit == $past(shift_ff[6]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not stored");
  property p_slew_map;
    @(posedge clk) disable iff (!rstn)
    $past(rstn) |-> slew_uv_per_us == ($past(slp_ff[6]) ? 9'h17C : 9'h0BE);
  endproperty
  a_slew_map: assert property (p_slew_map) else $error("slew select wrong");
  property p_rdly_map;
    @(posedge clk) disable iff (!rstn)
    $past(rstn) |-> reset_delay_cycles ==
      ($past(slp_ff[7]) ? 20'(RDLY_LONG_CYC) : 20'(RDLY_SHORT_CYC));
  endproperty
  a_rdly_map: assert property (p_rdly_map) else $error("reset delay wrong");
endmodule
`default_nettype wire

/* sim/bsv_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bsv_defines.svh"

// ************************************************************
// host model: two-wire bus master
// ************************************************************
module bsv_host (
  // clock
  input  wire logic clk,
  // bus pins
  input  wire logic sda_oe,
  output var  logic scl_line,
  output logic      sda_line
);
  logic sda_m_ff;

  // open drain: the pull-up wins unless someone pulls low
  assign sda_line = sda_m_ff & ~sda_oe;

  // bus idles high at time zero
  initial begin
    scl_line = 1'b1;
    sda_m_ff = 1'b1;
  end

  // four clocks per phase, twice the minimum, to leave margin
  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  // one scl pulse, line sampled late in the high phase
  task automatic pulse(output logic smp);
    half();
    scl_line <= 1'b1;
    half();
    smp = sda_line;
    scl_line <= 1'b0;
  endtask

  // start, also used as repeated start
  task automatic start();
    @(posedge clk);
    sda_m_ff <= 1'b1;
    half();
    scl_line <= 1'b1;
    half();
    sda_m_ff <= 1'b0;
    half();
    scl_line <= 1'b0;
  endtask

  // stop leaves both lines idle high
  task automatic stop();
    @(posedge clk);
    sda_m_ff <= 1'b0;
    half();
    scl_line <= 1'b1;
    half();
    sda_m_ff <= 1'b1;
    half();
  endtask

  // byte out, msb first, then the target's acknowledge
  task automatic tx(input logic [7:0] b, output logic ack);
    logic smp;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      sda_m_ff <= b[i];
      pulse(smp);
    end
    @(posedge clk);
    sda_m_ff <= 1'b1;
    pulse(smp);
    ack = ~smp;
  endtask

  // byte in, master acknowledges only when more is wanted
  task automatic rx(input logic more, output logic [7:0] b);
    logic smp;
    @(posedge clk);
    sda_m_ff <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(smp);
      b[i] = smp;
      @(posedge clk);
    end
    sda_m_ff <= ~more;
    pulse(smp);
    @(posedge clk);
    sda_m_ff <= 1'b1;
  endtask

  // register write: address, pointer, one data byte
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                    output logic ack);
    logic a1;
    logic a2;
    logic a3;
    start();
    tx({dev, 1'b0}, a1);
    tx(ptr, a2);
    tx(d, a3);
    stop();
    ack = a1 & a2 & a3;
  endtask

  // register read: pointer write, repeated start, one byte
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ack);
    logic a1;
    logic a2;
    logic a3;
    start();
    tx({`BSV_TARGET_ADDR, 1'b0}, a1);
    tx(ptr, a2);
    start();
    tx({`BSV_TARGET_ADDR, 1'b1}, a3);
    rx(1'b0, d);
    stop();
    ack = a1 & a2 & a3;
  endtask
endmodule
`default_nettype wire

/* sim/buck_sleep_voltage_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bsv_defines.svh"

module buck_sleep_voltage_regs_test;
  // short delay counts keep the run brief
  localparam int unsigned SHORT_CYC = 10;
  localparam int unsigned LONG_CYC  = 80;

  logic        clk;
  logic        rstn;
  logic        scl_line;
  logic        sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic        osc_enable;
  logic        converter_enable_bit;
  logic [5:0]  converter_voltage_code;
  logic [11:0] main_target_mv;
  logic [5:0]  light_load_voltage_code;
  logic        output_slew_rate_select;
  logic        reset_delay_select;
  logic [11:0] sleep_target_mv;
  logic [8:0]  slew_uv_per_us;
  logic [19:0] reset_delay_cycles;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [7:0]  sweep [5] = '{8'h8A, 8'h00, 8'h3F, 8'h7F, 8'hC0};

  bsv_regs #(.RDLY_SHORT_CYC(SHORT_CYC), .RDLY_LONG_CYC(LONG_CYC)) dut_u (
    .clk(clk), .rstn(rstn), .scl_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .osc_enable(osc_enable),
    .converter_enable_bit(converter_enable_bit),
    .converter_voltage_code(converter_voltage_code), .main_target_mv(main_target_mv),
    .light_load_voltage_code(light_load_voltage_code),
    .output_slew_rate_select(output_slew_rate_select),
    .reset_delay_select(reset_delay_select), .sleep_target_mv(sleep_target_mv),
    .slew_uv_per_us(slew_uv_per_us), .reset_delay_cycles(reset_delay_cycles)
  );

  bsv_host host_u (.clk(clk), .sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line));

  // ************************************************************
  // checking helpers
  // ************************************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // sleep register fields, derived targets and read-back
  task automatic chk_slp(input logic [7:0] v);
    logic [7:0] d;
    logic       ack;
    repeat (3) @(posedge clk);
    chk(light_load_voltage_code, v[5:0]);
    chk(output_slew_rate_select, v[6]);
    chk(reset_delay_select, v[7]);
    chk(sleep_target_mv, 20'h271 + 20'h19 * v[5:0]);
    chk(slew_uv_per_us, v[6] ? 20'h17C : 20'hBE);
    chk(reset_delay_cycles, v[7] ? 20'(LONG_CYC) : 20'(SHORT_CYC));
    chk(sda_out, 1'b0);
    host_u.rd(`BSV_REG_SLP, d, ack);
    chk(d, v);
    chk(ack, 1'b1);
  endtask

  // main register enable and code
  task automatic chk_main(input logic [7:0] v);
    logic [7:0] d;
    logic       ack;
    repeat (3) @(posedge clk);
    chk(converter_enable_bit, v[6]);
    chk(main_target_mv, 20'h271 + 20'h19 * v[5:0]);
    chk(converter_voltage_code, v[5:0]);
    chk(osc_enable, v[7]);
    host_u.rd(`BSV_REG_CTL, d, ack);
    chk(d, v);
    chk(ack, 1'b1);
  endtask

  // ************************************************************
  // clock and hang guard
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a run needs about 8000 cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      close_out();
    end
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    logic [7:0] d;
    logic       ack;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk_slp(`BSV_SLP_RESET);
    chk_main(`BSV_CTL_RESET);
    $display("test defaults done");
    // every field at both ends of its range
    foreach (sweep[i]) begin
      host_u.wr(`BSV_TARGET_ADDR, `BSV_REG_SLP, sweep[i], ack);
      chk(ack, 1'b1);
      chk_slp(sweep[i]);
    end
    $display("test sweep done");
    // another address must be ignored
    host_u.wr(7'h6D, `BSV_REG_SLP, 8'h55, ack);
    chk(ack, 1'b0);
    chk_slp(8'hC0);
    $display("test address done");
    // converter is switched off before its code changes
    host_u.wr(`BSV_TARGET_ADDR, `BSV_REG_CTL, 8'h8F, ack);
    chk_main(8'h8F);
    host_u.wr(`BSV_TARGET_ADDR, `BSV_REG_CTL, 8'hC5, ack);
    chk_main(8'hC5);
    $display("test enable done");
    // burst read: master ack walks the pointer from 0x02 into 0x03
    host_u.start();
    host_u.tx({`BSV_TARGET_ADDR, 1'b0}, ack);
    host_u.tx(`BSV_REG_CTL, ack);
    host_u.start();
    host_u.tx({`BSV_TARGET_ADDR, 1'b1}, ack);
    chk(ack, 1'b1);
    host_u.rx(1'b1, d);
    chk(d, 8'hC5);
    host_u.rx(1'b0, d);
    chk(d, 8'hC0);
    host_u.stop();
    $display("test burst done");
    // unmapped offset drops writes and reads zero
    host_u.wr(`BSV_TARGET_ADDR, 8'h05, 8'h3C, ack);
    chk(ack, 1'b1);
    host_u.rd(8'h05, d, ack);
    chk(d, 8'h00);
    chk(ack, 1'b1);
    chk_slp(8'hC0);
    $display("test unmapped done");
    // second reset mid-run restores defaults
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk_slp(`BSV_SLP_RESET);
    chk_main(`BSV_CTL_RESET);
    $display("test rereset done");
    close_out();
  end
endmodule
`default_nettype wire
